// ==== print_sched_defines.svh ====
// Constants for the reading print scheduler: register offsets, reset values, field codes and timing counts.
// Assumes a 10 MHz clock and a 32-bit APB register bus.
`ifndef PRINT_SCHED_DEFINES_SVH
`define PRINT_SCHED_DEFINES_SVH
`define CLK_HZ 10000000
// Register byte offsets.
`define OFF_SERIAL 12'h000
`define OFF_PRINT 12'h004
`define OFF_MEAS 12'h008
`define OFF_STATUS 12'h00c
`define OFF_READING 12'h010
`define OFF_SECOND 12'h014
// Serial field reset values: 9600 baud code 5, no parity, 8 bits, 1 stop, echo off.
`define BAUD_RESET 3'h5
`define PAR_RESET 2'h0
`define BITS8_RESET 1'h1
`define STOP2_RESET 1'h0
`define ECHO_RESET 1'h0
// Measurement field codes; power-up defaults are DC volts, autorange, slow rate, trigger type 1.
`define FUNC_DCV 3'h0
`define FUNC_FREQ 3'h5
`define FUNC_DIODE 3'h6
`define FUNC_CONT 3'h7
`define RATE_SLOW 2'h0
`define RATE_MED 2'h1
`define RATE_FAST 2'h2
`define TRIG_INTERNAL 3'h1
// Reading tick periods in microseconds.
`define TICK_SLOW_US 400000
`define TICK_MED_US 50000
`define TICK_FAST_US 10000
`define TICK_FREQ_US 250000
`define US_CYCLES(us) ((`CLK_HZ / 1000000) * (us))
// Select key hold time in milliseconds.
`define HOLD_MS 2000
`define HOLD_CYCLES ((`CLK_HZ / 1000) * `HOLD_MS)
`endif

// ==== print_sched_pkg.sv ====
// Types for the reading print scheduler.
// Shared by the design and the verification side.
package print_sched_pkg;
	// Serial link configuration, held in non-volatile storage.
	typedef struct packed {
		logic [2:0] baud;
		logic [1:0] parity;
		logic bits8;
		logic stop2;
		logic echo;
	} serial_cfg_s;
	// Measurement settings.
	typedef struct packed {
		logic [2:0] func;
		logic autorange;
		logic [1:0] rate;
		logic [2:0] trig;
		logic rel_show;
		logic dual;
	} meas_cfg_s;
	// Print scheduler states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_SEND = 3'b100
	} sched_state_e;
endpackage : print_sched_pkg

// ==== reading_print_scheduler.sv ====
// Serial configuration keeper and print-only scheduler with an APB register port.
// Assumes a non-volatile store outside that presents saved serial settings and takes writes.
`timescale 1ns/1ps
`include "print_sched_defines.svh"
module reading_print_scheduler
	import print_sched_pkg::*;
#(
	parameter int HOLD_CYCLES = `HOLD_CYCLES,
	parameter int TICK_SLOW = `US_CYCLES(`TICK_SLOW_US),
	parameter int TICK_MED = `US_CYCLES(`TICK_MED_US),
	parameter int TICK_FAST = `US_CYCLES(`TICK_FAST_US),
	parameter int TICK_FREQ = `US_CYCLES(`TICK_FREQ_US)
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] nv_cfg,
	input wire logic nv_valid,
	output logic [7:0] nv_wdata,
	output logic nv_we,
	input wire logic panel_serial_we,
	input wire logic [7:0] panel_serial_cfg,
	input wire logic serial_selected,
	input wire logic [3:0] panel_rate_idx,
	input wire logic select_key,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	output logic echo_valid,
	output logic [7:0] echo_char,
	output logic print_req,
	output logic print_dual,
	output logic link_active,
	output logic [7:0] serial_cfg_out
);
	// Print rate table; index 0 is off.
	function automatic logic [15:0] rate_value(input logic [3:0] idx);
		case (idx)
			4'h0: rate_value = 16'h0000;
			4'h1: rate_value = 16'h0001;
			4'h2: rate_value = 16'h0002;
			4'h3: rate_value = 16'h0005;
			4'h4: rate_value = 16'h000a;
			4'h5: rate_value = 16'h0014;
			4'h6: rate_value = 16'h0032;
			4'h7: rate_value = 16'h0064;
			4'h8: rate_value = 16'h00c8;
			4'h9: rate_value = 16'h01f4;
			4'ha: rate_value = 16'h03e8;
			4'hb: rate_value = 16'h07d0;
			4'hc: rate_value = 16'h1388;
			4'hd: rate_value = 16'h2710;
			4'he: rate_value = 16'h4e20;
			4'hf: rate_value = 16'hc350;
			default: rate_value = 16'h0000;
		endcase
	endfunction : rate_value

	// Tick period in cycles for a function and rate setting.
	function automatic logic [31:0] tick_period(input logic [2:0] func, input logic [1:0] rate);
		if (func == `FUNC_FREQ) begin
			tick_period = 32'(TICK_FREQ);
		end else if (func == `FUNC_DIODE || func == `FUNC_CONT) begin
			tick_period = 32'(TICK_FAST);
		end else begin
			case (rate)
				`RATE_SLOW: tick_period = 32'(TICK_SLOW);
				`RATE_MED: tick_period = 32'(TICK_MED);
				default: tick_period = 32'(TICK_FAST);
			endcase
		end
	endfunction : tick_period

	// Panel and remote inputs come from other logic; the key and pins are synchronised.
	logic [1:0] key_sync_reg;
	logic [1:0] nvv_sync_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			key_sync_reg <= 2'h0;
			nvv_sync_reg <= 2'h0;
		end else begin
			key_sync_reg <= {key_sync_reg[0], select_key};
			nvv_sync_reg <= {nvv_sync_reg[0], nv_valid};
		end
	end

	// Serial configuration; reset value is factory, replaced by the stored copy once it is valid.
	serial_cfg_s ser_reg; // Live serial settings.
	logic loaded_reg; // Stored copy has been taken.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ser_reg <= '{baud: `BAUD_RESET, parity: `PAR_RESET, bits8: `BITS8_RESET,
				stop2: `STOP2_RESET, echo: `ECHO_RESET};
			loaded_reg <= 1'b0;
			link_active <= 1'b0;
		end else begin
			if (!loaded_reg && nvv_sync_reg[1]) begin
				ser_reg <= serial_cfg_s'(nv_cfg);
				loaded_reg <= 1'b1;
			end else if (loaded_reg && panel_serial_we) begin
				// Only the panel path may write; the APB view is read-only here.
				ser_reg <= serial_cfg_s'(panel_serial_cfg);
			end
			link_active <= loaded_reg;
		end
	end

	// Every panel change is also written through to the non-volatile store.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			nv_we <= 1'b0;
			nv_wdata <= 8'h00;
			serial_cfg_out <= 8'h00;
		end else begin
			nv_we <= loaded_reg && panel_serial_we;
			nv_wdata <= panel_serial_cfg;
			// Data bit count and framing go to the UART unchanged; host matches them.
			serial_cfg_out <= ser_reg;
		end
	end

	// Echo path: a command character is looped back only with echo on and never blocked by printing.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			echo_valid <= 1'b0;
			echo_char <= 8'h00;
		end else begin
			echo_valid <= rx_valid && ser_reg.echo && link_active;
			echo_char <= ser_reg.bits8 ? rx_char : {1'b0, rx_char[6:0]};
		end
	end

	// Measurement settings, loaded with power-up defaults; only meas_reg is writable over APB, the compare, relative and min/max registers only clear at reset.
	meas_cfg_s meas_reg;
	logic [31:0] cmp_hi_reg, cmp_lo_reg, rel_base_reg, min_reg, max_reg;
	logic apb_wr;
	assign apb_wr = psel && penable && pwrite;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meas_reg <= '{func: `FUNC_DCV, autorange: 1'b1, rate: `RATE_SLOW,
				trig: `TRIG_INTERNAL, rel_show: 1'b0, dual: 1'b0};
			cmp_hi_reg <= 32'h0;
			cmp_lo_reg <= 32'h0;
			rel_base_reg <= 32'h0;
			min_reg <= 32'h0;
			max_reg <= 32'h0;
		end else if (apb_wr && paddr == `OFF_MEAS) begin
			meas_reg <= meas_cfg_s'(pwdata[10:0]);
		end
	end

	// Print-rate editor: offered only with the serial interface, committed after a two-second hold.
	logic [31:0] hold_cnt_reg; // Cycles the key has been held.
	logic [3:0] rate_idx_reg; // Committed print rate.
	logic rate_changed_reg; // One-cycle pulse on a commit.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hold_cnt_reg <= 32'h0;
			rate_idx_reg <= 4'h0;
			rate_changed_reg <= 1'b0;
		end else begin
			rate_changed_reg <= 1'b0;
			if (!key_sync_reg[1] || !serial_selected) begin
				hold_cnt_reg <= 32'h0;
			end else if (hold_cnt_reg == 32'(HOLD_CYCLES - 1)) begin
				hold_cnt_reg <= hold_cnt_reg + 32'h1;
				rate_idx_reg <= panel_rate_idx;
				rate_changed_reg <= 1'b1;
			end else if (hold_cnt_reg < 32'(HOLD_CYCLES)) begin
				hold_cnt_reg <= hold_cnt_reg + 32'h1;
			end
		end
	end

	// Reading tick generator; period follows function and rate.
	logic [31:0] tick_cnt_reg;
	logic tick_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg + 32'h1 >= tick_period(meas_reg.func, meas_reg.rate)) begin
			tick_cnt_reg <= 32'h0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
			tick_reg <= 1'b0;
		end
	end

	// Decimation state machine; counts readings and requests a line at the N-th.
	sched_state_e state_reg;
	logic [15:0] dec_cnt_reg;
	logic [15:0] n_value;
	assign n_value = rate_value(rate_idx_reg);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			dec_cnt_reg <= 16'h0;
			print_req <= 1'b0;
			print_dual <= 1'b0;
		end else begin
			print_req <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					dec_cnt_reg <= 16'h0;
					// Rate zero keeps the scheduler parked.
					if (n_value != 16'h0 && link_active) begin
						state_reg <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (n_value == 16'h0 || rate_changed_reg) begin
						state_reg <= n_value == 16'h0 ? ST_IDLE : ST_ARMED;
						dec_cnt_reg <= 16'h0;
					end else if (tick_reg) begin
						if (dec_cnt_reg + 16'h1 >= n_value) begin
							dec_cnt_reg <= 16'h0;
							state_reg <= ST_SEND;
						end else begin
							dec_cnt_reg <= dec_cnt_reg + 16'h1;
						end
					end
				end
				ST_SEND: begin
					// One line: one or two measurements depending on the dual display.
					print_req <= 1'b1;
					print_dual <= meas_reg.dual;
					state_reg <= ST_ARMED;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// APB slave: zero wait states; unmapped addresses read zero and flag an error.
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = a == `OFF_SERIAL || a == `OFF_PRINT || a == `OFF_MEAS || a == `OFF_STATUS
			|| a == `OFF_READING || a == `OFF_SECOND;
	endfunction : addr_known

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_known(paddr);
			case (paddr)
				`OFF_SERIAL: prdata <= {24'h0, ser_reg};
				`OFF_PRINT: prdata <= {12'h0, rate_idx_reg, n_value};
				`OFF_MEAS: prdata <= {21'h0, meas_reg};
				`OFF_STATUS: prdata <= {16'h0, dec_cnt_reg[12:0], state_reg};
				`OFF_READING: prdata <= cmp_hi_reg | rel_base_reg | min_reg;
				`OFF_SECOND: prdata <= cmp_lo_reg | max_reg;
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule : reading_print_scheduler

// ==== print_sched_chk.sv ====
// Port checker for the print scheduler: echo, serial settings and print pulses.
// Assumes binding to the top module; one clock domain.
`timescale 1ns/1ps
module print_sched_chk
	import print_sched_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic echo_valid,
	input wire logic [7:0] echo_char,
	input wire logic [7:0] serial_cfg_out,
	input wire logic link_active,
	input wire logic print_req,
	input wire logic panel_serial_we,
	input wire logic [7:0] panel_serial_cfg,
	input wire logic nv_we
);
	// Bit 0 is echo and bit 2 selects eight data bits.
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	chk_echo_off: assert property (rx_valid && !serial_cfg_out[0] |=> !echo_valid)
		else $error("echo while disabled");
	chk_echo_on: assert property (rx_valid && serial_cfg_out[0] && link_active |=> echo_valid &&
		echo_char[6:0] == $past(rx_char[6:0])) else $error("echo missing or wrong");
	chk_echo_seven: assert property (echo_valid && !serial_cfg_out[2] |-> !echo_char[7])
		else $error("eighth bit in seven-bit mode");
	chk_remote_cfg: assert property (rx_valid && link_active && !panel_serial_we |=> $stable(serial_cfg_out))
		else $error("serial settings moved by the link");
	chk_print_link: assert property (print_req |-> link_active)
		else $error("print before link active");
	chk_print_pulse: assert property (print_req |=> !print_req)
		else $error("print request too long");
	// The live copy is registered once more on its way out, so the new value shows two edges after the write.
	chk_panel_cfg: assert property (panel_serial_we && link_active |=> ##1 serial_cfg_out == $past(panel_serial_cfg, 2))
		else $error("panel setting not taken");
	chk_nv_write: assert property (panel_serial_we && link_active |-> ##[1:2] nv_we)
		else $error("panel setting not stored");
endmodule : print_sched_chk

// ==== nv_store_model.sv ====
// Model of the non-volatile store that keeps the serial settings.
// Assumes its power input follows the device reset.
`timescale 1ns/1ps
module nv_store_model
	import print_sched_pkg::*;
#(
	parameter logic [7:0] INIT = 8'h73
) (
	input wire logic clock,
	input wire logic power_n,
	input wire logic [7:0] nv_wdata,
	input wire logic nv_we,
	output logic [7:0] nv_cfg,
	output logic nv_valid
);
	logic [7:0] mem = INIT; // Survives every reset, like real storage.
	logic [2:0] wake; // Cycles since power returned.
	// Writes land at once and persist.
	always @(posedge clock) begin
		if (nv_we) mem <= nv_wdata;
	end
	// The store wakes slowly, so the device must wait for it.
	always @(posedge clock or negedge power_n) begin
		if (!power_n) wake <= 3'h0;
		else if (wake != 3'h7) wake <= wake + 3'h1;
	end
	assign nv_valid = (wake == 3'h7);
	// Before it is valid the data lines show garbage, not the stored value.
	assign nv_cfg = nv_valid ? mem : ~mem;
endmodule : nv_store_model

// ==== reading_print_scheduler_test.sv ====
// Testbench of the print scheduler: power-up, registers, echo and print pacing.
// Assumes the store model and the checker are compiled first.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module reading_print_scheduler_test
	import print_sched_pkg::*;
;
	logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic nv_valid, nv_we, panel_serial_we = 0, serial_selected = 1, select_key = 0, rx_valid = 0;
	logic echo_valid, print_req, print_dual, link_active;
	logic [7:0] nv_cfg, nv_wdata, panel_serial_cfg = '0, rx_char = '0, echo_char, serial_cfg_out;
	logic [3:0] panel_rate_idx = '0;
	int fails = 0, total_checks = 0, cycles = 0, n;
	// Short counts keep the run brief; expectations below follow them.
	reading_print_scheduler #(.HOLD_CYCLES(20), .TICK_SLOW(40), .TICK_MED(10), .TICK_FAST(5), .TICK_FREQ(25)) DUT (
		.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nv_cfg, .nv_valid,
		.nv_wdata, .nv_we, .panel_serial_we, .panel_serial_cfg, .serial_selected, .panel_rate_idx, .select_key,
		.rx_valid, .rx_char, .echo_valid, .echo_char, .print_req, .print_dual, .link_active, .serial_cfg_out);
	nv_store_model NV (.clock, .power_n(reset_n), .nv_wdata, .nv_we, .nv_cfg, .nv_valid);
	initial forever #50 clock = ~clock;
	// A hang counts as a mismatch.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end
	// One APB transfer; the answer is taken at the edge that sees pready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// One idle edge, so that a following call never re-raises psel in the same time step.
		@(posedge clock);
	endtask : apb
	task automatic power_up();
		reset_n <= 1'h0;
		repeat (6) @(posedge clock);
		reset_n <= 1'h1;
		repeat (2) @(posedge clock);
		`CHECK("factory cfg", 8'ha4, serial_cfg_out)
		`CHECK("link idle", 1'h0, link_active)
		n = 0;
		while (link_active !== 1'h1 && n < 50) begin
			@(posedge clock);
			n++;
		end
	endtask : power_up
	task automatic next_print(output int k);
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (print_req !== 1'h1 && k < 3000);
	endtask : next_print
	task automatic commit(input logic [3:0] idx, input int hold);
		panel_rate_idx <= idx;
		select_key <= 1'h1;
		repeat (hold) @(posedge clock);
		select_key <= 1'h0;
		repeat (4) @(posedge clock);
	endtask : commit
	task automatic echo(input logic [7:0] c, input logic v, input logic [7:0] x);
		rx_char <= c;
		rx_valid <= 1'h1;
		@(posedge clock);
		rx_valid <= 1'h0;
		@(posedge clock);
		`CHECK("echo valid", v, echo_valid)
		if (v) `CHECK("echo char", x, echo_char)
	endtask : echo
	task automatic t_power();
		power_up();
		`CHECK("stored cfg", 8'h73, serial_cfg_out)
		apb(1'h0, 12'h008, '0);
		`CHECK("meas defaults", 32'h84, q)
		apb(1'h0, 12'h014, '0);
		`CHECK("limits cleared", 32'h0, q)
		apb(1'h0, 12'h004, '0);
		`CHECK("print off", 32'h0, q)
		apb(1'h0, 12'h100, '0);
		`CHECK("unmapped", 1'h1, e)
		$display("power test done");
	endtask : t_power
	task automatic t_remote();
		apb(1'h1, 12'h000, 32'hff);
		`CHECK("remote write", 8'h73, serial_cfg_out)
		echo(8'hc1, 1'h1, 8'h41);
		panel_serial_cfg <= 8'h64;
		panel_serial_we <= 1'h1;
		@(posedge clock);
		panel_serial_we <= 1'h0;
		repeat (3) @(posedge clock);
		`CHECK("panel cfg", 8'h64, serial_cfg_out)
		echo(8'h41, 1'h0, 8'h0);
		power_up();
		`CHECK("kept cfg", 8'h64, serial_cfg_out)
		$display("serial test done");
	endtask : t_remote
	task automatic t_rates();
		int nv[15] = '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000};
		for (int i = 0; i < 15; i++) begin
			commit(4'(i + 1), 26);
			apb(1'h0, 12'h004, '0);
			`CHECK("rate", (32'(i + 1) << 16) | 32'(nv[i]), q)
		end
		$display("rate test done");
	endtask : t_rates
	// Third gap after each change, so the phase of the change does not matter.
	task automatic t_pace();
		logic [31:0] m[6] = '{32'h84, 32'ha4, 32'hc4, 32'h584, 32'h684, 32'hc5};
		int gap[6] = '{80, 20, 10, 50, 10, 10};
		commit(4'h2, 26);
		for (int i = 0; i < 6; i++) begin
			apb(1'h1, 12'h008, m[i]);
			repeat (3) next_print(n);
			`CHECK("gap", gap[i], n)
			`CHECK("dual", m[i][0], print_dual)
		end
		$display("pace test done");
	endtask : t_pace
	task automatic t_guard();
		commit(4'h5, 12);
		apb(1'h0, 12'h004, '0);
		`CHECK("short hold", 32'h20002, q)
		serial_selected <= 1'h0;
		commit(4'h5, 26);
		apb(1'h0, 12'h004, '0);
		`CHECK("not serial", 32'h20002, q)
		serial_selected <= 1'h1;
		commit(4'h0, 26);
		next_print(n);
		`CHECK("silent", 3000, n)
		$display("guard test done");
	endtask : t_guard
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	initial begin
		t_power();
		t_remote();
		t_rates();
		t_pace();
		t_guard();
		wrap_up();
	end
endmodule : reading_print_scheduler_test
bind reading_print_scheduler print_sched_chk CHK (.clock, .reset_n, .rx_valid, .rx_char, .echo_valid, .echo_char,
	.serial_cfg_out, .link_active, .print_req, .panel_serial_we, .panel_serial_cfg, .nv_we);
